//--- core/ast_defines.vh
// register map and constants of the serial transceiver
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH

`define AST_ADDR_STA        3'h0
`define AST_ADDR_MODE       3'h1
`define AST_ADDR_BAUD       3'h2
`define AST_ADDR_TXD        3'h3
`define AST_ADDR_RXD        3'h4

`define AST_STA_TXSEL1      15
`define AST_STA_TXINV       14
`define AST_STA_TXSEL0      13
`define AST_STA_BRK         11
`define AST_STA_TXEN        10
`define AST_STA_TXBF        9
`define AST_STA_TX_SHIFT_EMPTY        8
`define AST_STA_RXSEL1      7
`define AST_STA_RXSEL0      6
`define AST_STA_ADDRESS_DETECT_ENABLE       5
`define AST_STA_RX_IDLE       4
`define AST_STA_PARITY_ERROR        3
`define AST_STA_FRAMING_ERROR        2
`define AST_STA_OVERRUN_ERROR        1
`define AST_STA_RXDA        0

`define AST_MODE_NINE       0
`define AST_MODE_PAR_LO     1
`define AST_MODE_PAR_HI     2
`define AST_MODE_TWOSTOP    3
`define AST_MODE_FLOW       4
`define AST_MODE_LOOP       5
`define AST_MODE_QUAD       6
`define AST_MODE_INFRARED_ENABLE       7
`define AST_MODE_ABAUD      8
`define AST_MODE_WIDTH      9

`define AST_MODE_RST        9'h000
`define AST_BAUD_RST        16'h0019

`define AST_PAR_NONE        2'h0
`define AST_PAR_EVEN        2'h1
`define AST_PAR_ODD         2'h2

`define AST_OSR16_MAX       4'hf
`define AST_OSR4_MAX        4'h3
`define AST_IR16_WIDTH      4'h3
`define AST_IR4_WIDTH       4'h1
`define AST_FIFO_DEPTH      3'h4
`define AST_BRK_FRAME       14'h2000
`define AST_BRK_LEN         4'he
`define AST_SYNC_EDGES      3'h4
`define AST_AB16_SHIFT      5'h07
`define AST_AB4_SHIFT       5'h05

`endif

//--- core/ast_serial_transceiver.v
// full-duplex asynchronous serial transceiver with baud generator, four-deep buffers and infrared coding
//
// Contract
// R1 - full duplex, 8- or 9-bit characters
// R2 - even, odd or no parity for 8-bit
// R3 - one or two stop bits
// R4 - baud timing from 16-bit divider
// R5 - 16x and 4x oversampling modes
// R6 - four-deep transmit FIFO
// R7 - four-deep receive FIFO
// R8 - parity, framing, overrun errors; separate error request
// R9 - address detect accepts ninth bit one
// R10 - CTS input and RTS output pace transfers
// R11 - loopback routes transmit into receiver
// R12 - autobaud on sync; break and sync characters
// R13 - infrared encode/decode, 16x baud clock out; the clock out follows the sample rate, so it is 4x baud in 4x mode
// R14 - transmit interrupt select codes 00/10/01
// R15 - polarity bit sets transmit idle level
// R16 - break: start, twelve zeros, stop; self-clearing
// R17 - transmit disable aborts and resets buffer
// R18 - buffer full flag reads one when full
// R19 - shift-empty flag: shifter and buffer empty
// R20 - receive interrupt select codes
// R21 - idle and shift-empty reset one; overrun clearable
// R22 - data-available and head-character error flags
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ast_defines.vh"

module ast_serial_transceiver (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [2:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [15:0] regRdData,
    input  wire        serialInPin,
    input  wire        clearToSendIn_n,
    output reg         serialOutPin,
    output reg         serialOutOe,
    output reg         requestToSendOut_n,
    output reg         baudClk16Out,
    output reg         txIrq,
    output reg         rxIrq,
    output reg         errIrq
);

    localparam RX_IDLE  = 2'h0;
    localparam RX_START = 2'h1;
    localparam RX_DATA  = 2'h2;

    // status/control fields
    reg  [1:0]  txSel_r;
    reg         txInv_r;
    reg         brk_r;
    reg         txEn_r;
    reg  [1:0]  rxSel_r;
    reg         addrEn_r;
    reg         overrun_r;
    reg  [8:0]  mode_r;
    reg  [15:0] baud_r;

    reg  [15:0] brgCnt_r;
    reg  [3:0]  txOs_r;
    reg  [8:0]  txMem [0:3];
    reg  [1:0]  txWp_r;
    reg  [1:0]  txRp_r;
    reg  [2:0]  txCount_r;
    reg         txBusy_r;
    reg  [13:0] txFrame_r;
    reg  [3:0]  txLeft_r;
    reg         txIsBrk_r;

    reg  [10:0] rxMem [0:3];
    reg  [1:0]  rxWp_r;
    reg  [1:0]  rxRp_r;
    reg  [2:0]  rxCount_r;
    reg  [1:0]  rxState_r;
    reg  [3:0]  rxOs_r;
    reg  [3:0]  rxBit_r;
    reg  [10:0] rxShift_r;
    reg         irLow_r;
    reg  [3:0]  irCnt_r;
    reg         rxPrev_r;
    reg  [2:0]  abEdges_r;
    reg  [19:0] abCnt_r;

    wire        nine    = mode_r[`AST_MODE_NINE];
    wire [1:0]  parMode = mode_r[`AST_MODE_PAR_HI:`AST_MODE_PAR_LO];
    wire        twoStop = mode_r[`AST_MODE_TWOSTOP];
    wire        flowEn  = mode_r[`AST_MODE_FLOW];
    wire        loopEn  = mode_r[`AST_MODE_LOOP];
    wire        quad    = mode_r[`AST_MODE_QUAD];
    wire        infrared_enable    = mode_r[`AST_MODE_INFRARED_ENABLE];
    wire        abaudEn = mode_r[`AST_MODE_ABAUD];
    wire [3:0]  osrMax  = quad ? `AST_OSR4_MAX : `AST_OSR16_MAX; // R5

    // parity bit of a byte under the selected mode
    function parityOf;
        input [7:0] d;
        input [1:0] pm;
        begin
            parityOf = (pm == `AST_PAR_ODD) ? ~(^d) : (^d);
        end
    endfunction

    function wordBit;
        input [2:0] a;
        input [2:0] b;
        begin
            wordBit = (a == b);
        end
    endfunction

    wire wrSta  = regWr & wordBit(regAddr, `AST_ADDR_STA);
    wire wrMode = regWr & wordBit(regAddr, `AST_ADDR_MODE);
    wire wrBaud = regWr & wordBit(regAddr, `AST_ADDR_BAUD);
    wire wrTxd  = regWr & wordBit(regAddr, `AST_ADDR_TXD);
    wire rdRxd  = regRd & wordBit(regAddr, `AST_ADDR_RXD);

    // baud generator: tick every baud_r+1 clocks; >= so a lowered divider cannot stall
    wire sampleTick = (brgCnt_r >= baud_r);                          // R4
    wire bitTick    = sampleTick & (txOs_r == osrMax);

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brgCnt_r     <= 16'h0000;
            txOs_r       <= 4'h0;
            baudClk16Out <= 1'b0;
        end
        else
        begin
            brgCnt_r     <= sampleTick ? 16'h0000 : brgCnt_r + 16'h0001;
            if (sampleTick)
                txOs_r <= (txOs_r == osrMax) ? 4'h0 : txOs_r + 4'h1;
            // square wave at the sample rate
            baudClk16Out <= (brgCnt_r <= {1'b0, baud_r[15:1]});     // R13
        end
    end

    // transmit side
    wire txFull     = (txCount_r == `AST_FIFO_DEPTH);                // R18
    wire txEmpty    = (txCount_r == 3'h0);
    wire ctsOk      = ~flowEn | ~clearToSendIn_n;                    // R10
    wire txIdleTick = bitTick & ~txBusy_r & txEn_r;
    wire txStartBrk = txIdleTick & brk_r;                            // R16
    wire txStartDat = txIdleTick & ~brk_r & ~txEmpty & ctsOk;        // R6
    wire txDone     = bitTick & txBusy_r & (txLeft_r == 4'h1);
    wire txPush     = wrTxd & txEn_r & ~txFull;
    wire tx_shift_empty       = ~txBusy_r & txEmpty;                           // R19
    wire [8:0] txHead = txMem[txRp_r];

    reg  [13:0] newFrame;
    reg  [3:0]  newLen;
    always @*
    begin
        newFrame       = {14{1'b1}};
        newFrame[0]    = 1'b0;
        newFrame[8:1]  = txHead[7:0];                                // R1
        newLen         = 4'h9;
        if (nine)
        begin
            newFrame[9] = txHead[8];
            newLen      = 4'ha;
        end
        else if (parMode != `AST_PAR_NONE)
        begin
            newFrame[9] = parityOf(txHead[7:0], parMode);            // R2
            newLen      = 4'ha;
        end
        newLen = newLen + (twoStop ? 4'h2 : 4'h1);                   // R3
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txWp_r    <= 2'h0;
            txRp_r    <= 2'h0;
            txCount_r <= 3'h0;
            txBusy_r  <= 1'b0;
            txFrame_r <= {14{1'b1}};
            txLeft_r  <= 4'h0;
            txIsBrk_r <= 1'b0;
        end
        else if (!txEn_r)
        begin
            // disable drops the queue and any character in flight
            txWp_r    <= 2'h0;                                       // R17
            txRp_r    <= 2'h0;
            txCount_r <= 3'h0;
            txBusy_r  <= 1'b0;
            txFrame_r <= {14{1'b1}};
            txLeft_r  <= 4'h0;
            txIsBrk_r <= 1'b0;
        end
        else
        begin
            if (txPush)
            begin
                txMem[txWp_r] <= regWrData[8:0];
                txWp_r        <= txWp_r + 2'h1;
            end
            if (txStartDat)
                txRp_r <= txRp_r + 2'h1;
            case ({txPush, txStartDat})
                2'b10:   txCount_r <= txCount_r + 3'h1;
                2'b01:   txCount_r <= txCount_r - 3'h1;
                default: txCount_r <= txCount_r;
            endcase
            if (txStartBrk)
            begin
                txBusy_r  <= 1'b1;
                txFrame_r <= `AST_BRK_FRAME;
                txLeft_r  <= `AST_BRK_LEN;
                txIsBrk_r <= 1'b1;
            end
            else if (txStartDat)
            begin
                txBusy_r  <= 1'b1;
                txFrame_r <= newFrame;
                txLeft_r  <= newLen;
                txIsBrk_r <= 1'b0;
            end
            else if (bitTick & txBusy_r)
            begin
                txFrame_r <= {1'b1, txFrame_r[13:1]};
                txLeft_r  <= txLeft_r - 4'h1;
                if (txDone)
                    txBusy_r <= 1'b0;
            end
        end
    end

    wire txLine   = txBusy_r ? txFrame_r[0] : 1'b1;
    // infrared: a short high pulse for each zero bit, nothing for ones
    wire irPulse  = ~txLine & (txOs_r < (quad ? `AST_IR4_WIDTH : `AST_IR16_WIDTH));

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serialOutPin <= 1'b1;
            serialOutOe  <= 1'b0;
        end
        else
        begin
            serialOutOe  <= txEn_r;                                  // R17
            serialOutPin <= (infrared_enable ? irPulse : txLine) ^ txInv_r;     // R15 R13
        end
    end

    // receive side
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irLow_r <= 1'b0;
            irCnt_r <= 4'h0;
        end
        else if (serialInPin)
        begin
            irLow_r <= 1'b1;                                         // R13
            irCnt_r <= 4'h0;
        end
        else if (sampleTick & irLow_r)
        begin
            irCnt_r <= irCnt_r + 4'h1;
            if (irCnt_r == osrMax)
                irLow_r <= 1'b0;
        end
    end

    wire rxLine = loopEn ? txLine : (infrared_enable ? ~irLow_r : serialInPin); // R11
    wire [3:0] rxNeed = ((nine | (parMode != `AST_PAR_NONE)) ? 4'ha : 4'h9);
    wire rxSample = sampleTick & (rxOs_r == osrMax) & (rxState_r == RX_DATA);
    wire rxLast   = rxSample & (rxBit_r == rxNeed - 4'h1);
    wire ferrNow  = ~rxLine;                                         // R8
    wire perrNow  = ~nine & (parMode != `AST_PAR_NONE) &
                    (rxShift_r[8] != parityOf(rxShift_r[7:0], parMode));
    wire addrOk   = ~(addrEn_r & nine) | rxShift_r[8];               // R9
    wire rxPush   = rxLast & addrOk;
    wire rxFull   = (rxCount_r == `AST_FIFO_DEPTH);
    wire rxPushOk = rxPush & ~rxFull;                                // R7
    wire rxOvr    = rxPush & rxFull;                                 // R8
    wire rxPop    = rdRxd & (rxCount_r != 3'h0);
    wire [10:0] rxHead = rxMem[rxRp_r];

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxState_r <= RX_IDLE;
            rxOs_r    <= 4'h0;
            rxBit_r   <= 4'h0;
            rxShift_r <= 11'h000;
        end
        else
        begin
            case (rxState_r)
                RX_IDLE:
                begin
                    rxOs_r <= 4'h0;
                    if (!rxLine && !abaudEn)
                        rxState_r <= RX_START;
                end
                RX_START:
                begin
                    if (sampleTick)
                    begin
                        rxOs_r <= rxOs_r + 4'h1;
                        if (rxOs_r == {1'b0, osrMax[3:1]})
                        begin
                            rxOs_r    <= 4'h0;
                            rxBit_r   <= 4'h0;
                            rxState_r <= rxLine ? RX_IDLE : RX_DATA;
                        end
                    end
                end
                RX_DATA:
                begin
                    if (sampleTick)
                        rxOs_r <= (rxOs_r == osrMax) ? 4'h0 : rxOs_r + 4'h1;
                    if (rxSample)
                    begin
                        rxShift_r[rxBit_r] <= rxLine;
                        rxBit_r            <= rxBit_r + 4'h1;
                        if (rxLast)
                            rxState_r <= RX_IDLE;
                    end
                end
                default: rxState_r <= RX_IDLE;
            endcase
        end
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxWp_r    <= 2'h0;
            rxRp_r    <= 2'h0;
            rxCount_r <= 3'h0;
        end
        else
        begin
            if (rxPushOk)
            begin
                rxMem[rxWp_r] <= {ferrNow, perrNow, nine & rxShift_r[8], rxShift_r[7:0]};
                rxWp_r        <= rxWp_r + 2'h1;
            end
            if (rxPop)
                rxRp_r <= rxRp_r + 2'h1;
            case ({rxPushOk, rxPop})
                2'b10:   rxCount_r <= rxCount_r + 3'h1;
                2'b01:   rxCount_r <= rxCount_r - 3'h1;
                default: rxCount_r <= rxCount_r;
            endcase
        end
    end

    // autobaud: clocks across the four low-high pairs of a sync character
    wire rxFall = rxPrev_r & ~rxLine;
    wire abDone = abaudEn & rxFall & (abEdges_r == `AST_SYNC_EDGES);  // R12
    wire [19:0] abDiv = abCnt_r >> (quad ? `AST_AB4_SHIFT : `AST_AB16_SHIFT);

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxPrev_r  <= 1'b1;
            abEdges_r <= 3'h0;
            abCnt_r   <= 20'h00000;
        end
        else
        begin
            rxPrev_r <= rxLine;
            if (!abaudEn || abDone)
            begin
                abEdges_r <= 3'h0;
                abCnt_r   <= 20'h00000;
            end
            else
            begin
                if (abEdges_r != 3'h0)
                    abCnt_r <= abCnt_r + 20'h00001;
                if (rxFall)
                    abEdges_r <= abEdges_r + 3'h1;
            end
        end
    end

    // software registers
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txSel_r   <= 2'h0;
            txInv_r   <= 1'b0;
            brk_r     <= 1'b0;
            txEn_r    <= 1'b0;
            rxSel_r   <= 2'h0;
            addrEn_r  <= 1'b0;
            overrun_r <= 1'b0;                                       // R21
            mode_r    <= `AST_MODE_RST;
            baud_r    <= `AST_BAUD_RST;
        end
        else
        begin
            if (wrSta)
            begin
                txSel_r  <= {regWrData[`AST_STA_TXSEL1], regWrData[`AST_STA_TXSEL0]};
                txInv_r  <= regWrData[`AST_STA_TXINV];
                txEn_r   <= regWrData[`AST_STA_TXEN];
                rxSel_r  <= regWrData[`AST_STA_RXSEL1:`AST_STA_RXSEL0];
                addrEn_r <= regWrData[`AST_STA_ADDRESS_DETECT_ENABLE];
            end
            // software set of break wins over the completion clear
            if (wrSta && regWrData[`AST_STA_BRK])
                brk_r <= 1'b1;
            else if (!txEn_r || (txDone && txIsBrk_r))
                brk_r <= 1'b0;                                       // R16
            // overrun: hardware set wins over a zero write
            if (rxOvr)
                overrun_r <= 1'b1;                                   // R8
            else if (wrSta && !regWrData[`AST_STA_OVERRUN_ERROR])
                overrun_r <= 1'b0;                                   // R21
            if (wrMode)
                mode_r <= regWrData[`AST_MODE_WIDTH-1:0];
            else if (abDone)
                mode_r[`AST_MODE_ABAUD] <= 1'b0;
            if (wrBaud)
                baud_r <= regWrData;
            else if (abDone)
                baud_r <= (abDiv == 20'h00000) ? 16'h0000 : abDiv[15:0] - 16'h0001; // R12
        end
    end

    wire [15:0] staRead = {txSel_r[1], txInv_r, txSel_r[0], 1'b0, brk_r, txEn_r, txFull, tx_shift_empty,
                           rxSel_r, addrEn_r, (rxState_r == RX_IDLE),
                           (rxCount_r != 3'h0) & rxHead[9], (rxCount_r != 3'h0) & rxHead[10],
                           overrun_r, (rxCount_r != 3'h0)};          // R22 R21

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= 16'h0000;
        else if (regRd)
        begin
            case (regAddr)
                `AST_ADDR_STA:  regRdData <= staRead;
                `AST_ADDR_MODE: regRdData <= {7'h00, mode_r};
                `AST_ADDR_BAUD: regRdData <= baud_r;
                `AST_ADDR_RXD:  regRdData <= {7'h00, rxHead[8:0] & {9{rxCount_r != 3'h0}}};
                default:        regRdData <= 16'h0000;
            endcase
        end
        else
            regRdData <= 16'h0000;
    end

    // one-cycle request pulses and the registered RTS level
    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txIrq              <= 1'b0;
            rxIrq              <= 1'b0;
            errIrq             <= 1'b0;
            requestToSendOut_n <= 1'b1;
        end
        else
        begin
            case (txSel_r)                                           // R14
                2'h0:    txIrq <= txStartDat;
                2'h2:    txIrq <= txStartDat & (txCount_r == 3'h1) & ~txPush;
                2'h1:    txIrq <= txDone & txEmpty;
                default: txIrq <= 1'b0;
            endcase
            case (rxSel_r)                                           // R20
                2'h3:    rxIrq <= rxPushOk & (rxCount_r == 3'h3);
                2'h2:    rxIrq <= rxPushOk & (rxCount_r == 3'h2);
                default: rxIrq <= rxPushOk;
            endcase
            errIrq <= rxOvr | (rxPushOk & (ferrNow | perrNow));     // R8
            requestToSendOut_n <= ~(flowEn & ~rxFull);              // R10
        end
    end

endmodule // ast_serial_transceiver
`default_nettype wire

//--- sim/ast_chk.sv
// assertion checker bound to the serial transceiver top
`timescale 1ns/10ps
`default_nettype none
module ast_chk (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [2:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdData,
    input wire logic        serialOutPin,
    input wire logic        serialOutOe,
    input wire logic        requestToSendOut_n,
    input wire logic        txIrq,
    input wire logic        rxIrq
);
    logic [8:0] modeR;
    logic       invR;
    // mode and polarity shadows; autobaud self-clear not modelled
    always_ff @(posedge clock or negedge rst_n)
        if (!rst_n)
            {invR, modeR} <= 10'h000;
        else if (regWr && regAddr == 3'h1)
            modeR <= regWrData[8:0];
        else if (regWr && regAddr == 3'h0)
            invR <= regWrData[14];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_staRd; $past(regRd) && $past(regAddr) == 3'h0; endsequence
    sequence s_lowRun; !serialOutPin [*8]; endsequence
    property p_rdSlot; regRdData != 16'h0000 |-> $past(regRd); endproperty
    property p_txPulse; txIrq |=> !txIrq; endproperty
    property p_rxPulse; rxIrq |=> !rxIrq; endproperty
    property p_oeFollow; regWr && regAddr == 3'h0 |=> ##1 serialOutOe == $past(regWrData[10], 2); endproperty
    property p_rtsOff; !modeR[4] && !$past(modeR[4]) |-> requestToSendOut_n; endproperty
    property p_startLen; $fell(serialOutPin) && serialOutOe && modeR[7:6] == 2'b00 && !invR |-> s_lowRun; endproperty
    property p_fullEmpty; s_staRd ##0 regRdData[8] |-> !regRdData[9]; endproperty
    // pin lags status by a register; recent writes excluded
    property p_idleLvl;
        s_staRd ##0 regRdData[10] && regRdData[8] && !regRdData[11] && !modeR[7] && !$past(regWr)
            && !$past(regWr, 2) |-> serialOutPin == !regRdData[14];
    endproperty
    a_rdSlot: assert property (p_rdSlot) else $error("read data out of slot");
    a_txPulse: assert property (p_txPulse) else $error("tx pulse too long");
    a_rxPulse: assert property (p_rxPulse) else $error("rx pulse too long");
    a_oeFollow: assert property (p_oeFollow) else $error("oe not following enable");
    a_rtsOff: assert property (p_rtsOff) else $error("rts without flow control");
    a_startLen: assert property (p_startLen) else $error("low run too short");
    a_fullEmpty: assert property (p_fullEmpty) else $error("shifter empty while buffer full");
    a_idleLvl: assert property (p_idleLvl) else $error("idle level wrong for polarity");
endmodule // ast_chk
bind ast_serial_transceiver ast_chk u_chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .serialOutPin(serialOutPin),
    .serialOutOe(serialOutOe), .requestToSendOut_n(requestToSendOut_n), .txIrq(txIrq), .rxIrq(rxIrq));
`default_nettype wire

//--- sim/ast_remote_node.sv
// remote serial node: sends frames and decodes the transmit line
`timescale 1ns/10ps
`default_nettype none
module ast_remote_node #(parameter int BITCLK = 16) (
    input wire logic       clock,
    input wire logic       serialOutPin,
    input wire logic       requestToSendOut_n,
    input wire logic       flowOn,
    output var logic       serialInPin,
    output var logic [7:0] rxChar,
    output var logic       rxStrobe
);
    // even parity, one stop; badPar spoils the parity
    task automatic send(input logic [7:0] d, input logic badPar, input int gap);
        logic [10:0] fr;
        fr = {1'b1, ^d ^ badPar, d, 1'b0};
        repeat (gap) @(posedge clock);
        while (flowOn && requestToSendOut_n)
            @(posedge clock);
        for (int i = 0; i < 11; i++)
        begin
            serialInPin <= fr[i];
            repeat (BITCLK) @(posedge clock);
        end
    endtask
    initial
    begin
        serialInPin = 1'b1;
        rxStrobe = 1'b0;
        rxChar = 8'h00;
        forever
        begin
            @(negedge serialOutPin);
            repeat (BITCLK / 2) @(posedge clock);
            for (int i = 0; i < 9; i++)
            begin
                repeat (BITCLK) @(posedge clock);
                if (i < 8)
                    rxChar <= {serialOutPin, rxChar[7:1]};
                else
                    rxStrobe <= serialOutPin;
            end
            @(posedge clock);
            rxStrobe <= 1'b0;
            wait (serialOutPin);
        end
    end
endmodule // ast_remote_node
`default_nettype wire

//--- sim/ast_serial_transceiver_tb.sv
// self-checking bench for the serial transceiver
`timescale 1ns/10ps
`default_nettype none
module ast_serial_transceiver_tb;
    logic clock = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, ctsN = 1'b1, flowOn = 1'b0, rdPend = 1'b0;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWrData = 16'h0000, regRdData;
    logic serialInPin, serialOutPin, serialOutOe, requestToSendOut_n, baudClk16Out, txIrq, rxIrq, errIrq, rxStrobe;
    logic [7:0] rxChar;
    logic [7:0] rxE[4];
    logic [15:0] e;
    logic [15:0] rdQ[$];
    logic [7:0] txQ[$];
    logic [1:0] codes[3] = '{2'b01, 2'b10, 2'b00};
    int irqs[3] = '{1, 1, 4};
    int miscompares = 0, n_compared = 0, cyc = 0, nTx = 0, nRx = 0, nErr = 0;
    always #10 clock = ~clock;
    ast_serial_transceiver uut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .serialInPin(serialInPin), .clearToSendIn_n(ctsN),
        .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .requestToSendOut_n(requestToSendOut_n),
        .baudClk16Out(baudClk16Out), .txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq));
    ast_remote_node node (.clock(clock), .serialOutPin(serialOutPin), .requestToSendOut_n(requestToSendOut_n),
        .flowOn(flowOn), .serialInPin(serialInPin), .rxChar(rxChar), .rxStrobe(rxStrobe));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] x);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        rdQ.push_back(x);
        @(posedge clock);
        regRd <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        if (rdPend)
        begin
            e = rdQ.pop_front();
            cmp(regRdData, e);
        end
        rdPend <= regRd;
        if (rxStrobe === 1'b1)
            cmp({8'h00, rxChar}, {8'h00, txQ.pop_front()});
        if (txIrq === 1'b1)
            nTx++;
        if (rxIrq === 1'b1)
            nRx++;
        if (errIrq === 1'b1)
            nErr++;
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    initial
    begin
        logic [7:0] d;
        logic [15:0] s;
        int n;
        void'($urandom(4));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(3'h0, 16'h0110);
        rd(3'h1, 16'h0000);
        rd(3'h2, 16'h0019);
        rd(3'h5, 16'h0000);
        wr(3'h2, 16'h0000);
        wr(3'h1, 16'h0010);
        // cts held off so the buffer fills first
        foreach (codes[k])
        begin
            s = {codes[k][1], 1'b0, codes[k][0], 13'h0400};
            ctsN <= 1'b1;
            wr(3'h0, s);
            nTx = 0;
            for (int j = 0; j < 5; j++)
            begin
                d = 8'($urandom);
                wr(3'h3, {8'h00, d});
                if (j < 4)
                    txQ.push_back(d);
            end
            rd(3'h0, s | 16'h0210);
            ctsN <= 1'b0;
            for (int t = 0; t < 3000 && txQ.size() > 0; t++)
                @(posedge clock);
            repeat (40) @(posedge clock);
            rd(3'h0, s | 16'h0110);
            cmp(16'(nTx), 16'(irqs[k]));
        end
        wr(3'h1, 16'h0000);
        wr(3'h0, 16'h0c00);
        n = 0;
        for (int t = 0; t < 400 && serialOutPin; t++)
            @(posedge clock);
        while (!serialOutPin && n < 400)
        begin
            @(posedge clock);
            n++;
        end
        cmp(16'(n), 16'd208);
        repeat (40) @(posedge clock);
        rd(3'h0, 16'h0510);
        wr(3'h1, 16'h0012);
        flowOn <= 1'b1;
        nRx = 0;
        for (int i = 0; i < 4; i++)
        begin
            rxE[i] = 8'($urandom);
            node.send(rxE[i], i == 0, i * 5);
        end
        repeat (20) @(posedge clock);
        cmp(16'(requestToSendOut_n), 16'h0001);
        wr(3'h1, 16'h0002);
        flowOn <= 1'b0;
        node.send(8'($urandom), 1'b0, 0);
        repeat (20) @(posedge clock);
        rd(3'h0, 16'h051b);
        wr(3'h0, 16'h0400);
        for (int i = 0; i < 4; i++)
            rd(3'h4, {8'h00, rxE[i]});
        rd(3'h0, 16'h0510);
        cmp(16'(nRx), 16'd4);
        cmp(16'(nErr > 0), 16'd1);
        wr(3'h1, 16'h0021);
        d = 8'($urandom);
        txQ.push_back(d);
        wr(3'h3, {8'h01, d});
        repeat (200) @(posedge clock);
        rd(3'h4, {8'h01, d});
        wr(3'h1, 16'h0000);
        wr(3'h0, 16'h4400);
        repeat (4) @(posedge clock);
        cmp(16'(serialOutPin), 16'h0000);
        wr(3'h0, 16'h0000);
        repeat (3) @(posedge clock);
        cmp(16'(serialOutOe), 16'h0000);
        give_verdict();
    end
endmodule // ast_serial_transceiver_tb
`default_nettype wire
